// *** hdl/daq_scan_sequencer.sv ***
// Acquisition sequencer, waveform output and digital I/O behind an AHB-Lite slave
module daq_scan_sequencer #(
	parameter int AI_MAX_DIV = daq_pkg::CLK_HZ / daq_pkg::AI_MIN_SPS
) (
	input  wire logic             clock,
	input  wire logic             rst,
	input  wire logic             hsel,
	input  wire logic [31:0]      haddr,
	input  wire logic [1:0]       htrans,
	input  wire logic             hwrite,
	input  wire logic [2:0]       hsize,
	input  wire logic [31:0]      hwdata,
	input  wire logic             hready,
	output logic                  hreadyout,
	output logic                  hresp,
	output logic [31:0]           hrdata,
	output logic                  adcStart,
	output daq_pkg::adcReq_t      adcReq,
	input  wire logic             adcDone,
	input  wire logic [11:0]      adcData,
	output logic                  sampleValid,
	output daq_pkg::sample_t      sample,
	input  wire logic             extSampleClk,
	input  wire logic             extTrig,
	input  wire logic             analogCmp,
	output logic [7:0]            trigLevel,
	input  wire logic             aoClkIn,
	input  wire logic             aoTrigIn,
	output logic                  dacUpdate,
	output logic [11:0]           dacOut0,
	output logic [11:0]           dacOut1,
	input  wire logic [15:0]      dioIn,
	output logic [15:0]           dioOut,
	output logic [15:0]           dioOe,
	output logic [1:0]            auxOut
);
	import daq_pkg::*;

	logic [20:0] pinMeta_reg;
	logic [20:0] pinSync_reg;
	logic [4:0]  pinPrev_reg;
	wire  [20:0] pinRaw  = {dioIn, aoTrigIn, aoClkIn, analogCmp, extTrig, extSampleClk};
	wire  [4:0]  pinRise = pinSync_reg[4:0] & ~pinPrev_reg;
	wire  [15:0] dioSync = pinSync_reg[20:5];

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pinMeta_reg <= '0;
			pinSync_reg <= '0;
			pinPrev_reg <= '0;
		end else begin
			pinMeta_reg <= pinRaw;
			pinSync_reg <= pinMeta_reg;
			pinPrev_reg <= pinSync_reg[4:0];
		end
	end

	// Bus slave: zero wait states, read data captured in the address phase
	logic        dataWr_reg;
	logic [7:0]  wrAddr_reg;
	logic [31:0] hrdata_reg;
	logic [31:0] rdMux;
	wire addrPhase = hsel && htrans[1] && hready;
	wire wCtrl   = dataWr_reg && (wrAddr_reg == OFF_CTRL);
	wire wQData  = dataWr_reg && (wrAddr_reg == OFF_QDATA);
	wire wQAddr  = dataWr_reg && (wrAddr_reg == OFF_QADDR);
	wire wAoData = dataWr_reg && (wrAddr_reg == OFF_AODATA);
	wire wAoAddr = dataWr_reg && (wrAddr_reg == OFF_AOADDR);

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_reg;

	logic [31:0] ctrl_reg;
	logic [31:0] pacerDiv_reg;
	logic [31:0] sampTarget_reg;
	logic [7:0]  sweepTarget_reg;
	logic [31:0] interval_reg;
	logic [9:0]  qLast_reg;
	logic [9:0]  qWrIdx_reg;
	logic [7:0]  trigLevel_reg;
	logic [31:0] postTarget_reg;
	logic [12:0] aoLen_reg;
	logic [11:0] aoWrIdx_reg;
	logic [31:0] aoDiv_reg;
	logic [17:0] dio_reg;

	wire startCmd   = wCtrl && hwdata[CTRL_START];
	wire stopCmd    = wCtrl && hwdata[CTRL_STOP];
	wire aoStartCmd = wCtrl && hwdata[CTRL_AOSTART];
	wire aoStopCmd  = wCtrl && hwdata[CTRL_AOSTOP];
	// Mode fields come from the write that carries the start bit, not the stale register
	wire [1:0] startMode = hwdata[CTRL_ACQ +: 2];
	wire [1:0] startTrig = hwdata[CTRL_TRIG +: 2];
	wire [1:0] acqMode  = ctrl_reg[CTRL_ACQ +: 2];
	wire [1:0] trigMode = ctrl_reg[CTRL_TRIG +: 2];
	wire [1:0] trigSrc  = ctrl_reg[CTRL_SRC +: 2];
	wire [1:0] aoTrigSel = ctrl_reg[CTRL_AOTRIG +: 2];
	wire clkExt   = ctrl_reg[CTRL_CLKEXT];
	wire aoCyclic = ctrl_reg[CTRL_AOCYC];
	wire aoClkExt = ctrl_reg[CTRL_AOCLK];

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			dataWr_reg <= 1'b0;
			wrAddr_reg <= '0;
			hrdata_reg <= '0;
		end else begin
			dataWr_reg <= addrPhase && hwrite;
			if (addrPhase) begin
				wrAddr_reg <= haddr[7:0];
			end
			if (addrPhase && !hwrite) begin
				hrdata_reg <= rdMux;
			end
		end
	end

	// Start and stop bits are command pulses and are not stored
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ctrl_reg        <= CTRL_RST;
			pacerDiv_reg    <= PACER_RST;
			sampTarget_reg  <= '0;
			sweepTarget_reg <= '0;
			interval_reg    <= '0;
			qLast_reg       <= '0;
			qWrIdx_reg      <= '0;
			trigLevel_reg   <= TLEVEL_RST;
			postTarget_reg  <= '0;
			aoLen_reg       <= AOLEN_RST;
			aoWrIdx_reg     <= '0;
			aoDiv_reg       <= AODIV_RST;
			dio_reg         <= '0;
		end else if (dataWr_reg) begin
			case (wrAddr_reg)
				OFF_CTRL:     ctrl_reg <= hwdata & ~32'h0000_0603;
				OFF_PACER:    pacerDiv_reg <= hwdata;
				OFF_COUNT:    sampTarget_reg <= hwdata;
				OFF_SWEEPS:   sweepTarget_reg <= hwdata[7:0];
				OFF_INTERVAL: interval_reg <= hwdata;
				OFF_QLAST:    qLast_reg <= hwdata[9:0];
				OFF_QADDR:    qWrIdx_reg <= hwdata[9:0];
				OFF_QDATA:    qWrIdx_reg <= qWrIdx_reg + 10'h001;
				OFF_TLEVEL:   trigLevel_reg <= hwdata[7:0];
				OFF_POSTCNT:  postTarget_reg <= hwdata;
				OFF_AOLEN:    aoLen_reg <= hwdata[12:0];
				OFF_AOADDR:   aoWrIdx_reg <= hwdata[11:0];
				OFF_AODATA:   aoWrIdx_reg <= aoWrIdx_reg + 12'h001;
				OFF_AODIV:    aoDiv_reg <= hwdata;
				OFF_DIO:      dio_reg <= hwdata[17:0];
				default:      ;
			endcase
		end
	end

	// Storage is not reset; software loads it before use
	entry_t      queueMem [QUEUE_DEPTH];
	logic [23:0] aoMem [AO_DEPTH];
	always_ff @(posedge clock) begin
		if (wQData) begin
			queueMem[qWrIdx_reg] <= entry_t'(hwdata[9:0]);
		end
		if (wAoData) begin
			aoMem[aoWrIdx_reg] <= hwdata[23:0];
		end
	end

	// Pacer, clamped to the supported conversion rate range
	logic [31:0] pacerCnt_reg;
	wire [31:0] divEff = (pacerDiv_reg < AI_MIN_DIV) ? AI_MIN_DIV :
		(pacerDiv_reg > AI_MAX_DIV) ? AI_MAX_DIV : pacerDiv_reg;
	wire pacerTick = pacerCnt_reg >= divEff - 32'h1;
	wire paceTick  = clkExt ? pinRise[PIN_SCLK] : pacerTick;
	wire trigEvt   = (trigSrc == SRC_DIGITAL) ? pinRise[PIN_TRIG] :
		(trigSrc == SRC_ANALOG) ? pinRise[PIN_CMP] : pacerTick;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pacerCnt_reg <= '0;
		end else begin
			pacerCnt_reg <= pacerTick ? '0 : pacerCnt_reg + 32'h1;
		end
	end

	acqState_t   state_reg;
	logic [9:0]  qIdx_reg;
	logic [31:0] sampCnt_reg;
	logic [31:0] postCnt_reg;
	logic [7:0]  sweepCnt_reg;
	logic [31:0] intCnt_reg;
	logic        trigSeen_reg;
	logic        done_reg;
	logic        convBusy_reg;
	entry_t      curEntry;
	entry_t      singleEntry;

	assign singleEntry = '{sync: 2'h0, digital: 1'b0, gain: gain_t'(ctrl_reg[CTRL_SGAIN +: 2]),
		channel: ctrl_reg[CTRL_SCHAN +: 5]};
	assign curEntry = (acqMode == MODE_SINGLE) ? singleEntry : queueMem[qIdx_reg];

	wire running   = state_reg != S_IDLE;
	wire isScan    = acqMode == MODE_SCAN;
	wire isPaced   = acqMode == MODE_PACED;
	wire inConv    = state_reg == S_CONVERT;
	wire lastEntry = qIdx_reg == qLast_reg;
	wire lastSweep = sweepCnt_reg == sweepTarget_reg;
	wire convDone  = inConv && (curEntry.digital || (convBusy_reg && adcDone));
	wire countHit  = (sampTarget_reg != 32'h0) && (sampCnt_reg + 32'h1 >= sampTarget_reg);
	wire aboutHit  = trigSeen_reg && (trigMode == TRIG_ABOUT) && (postCnt_reg + 32'h1 >= postTarget_reg);
	// Pre and about modes watch for the trigger only once per acquisition
	wire trigLatch = running && isPaced && (trigMode != TRIG_POST) && trigEvt && !trigSeen_reg;
	wire preHit    = trigLatch && (trigMode == TRIG_PRE);
	wire finish    = convDone && ((acqMode == MODE_SINGLE) || countHit || aboutHit);

	assign adcStart = inConv && !curEntry.digital && !convBusy_reg;
	assign adcReq   = '{channel: curEntry.channel, gain: curEntry.gain};

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_reg    <= S_IDLE;
			qIdx_reg     <= '0;
			sampCnt_reg  <= '0;
			postCnt_reg  <= '0;
			sweepCnt_reg <= '0;
			intCnt_reg   <= '0;
			trigSeen_reg <= 1'b0;
			done_reg     <= 1'b0;
		end else begin
			if (convDone) begin
				sampCnt_reg <= sampCnt_reg + 32'h1;
			end
			if (convDone && trigSeen_reg) begin
				postCnt_reg <= postCnt_reg + 32'h1;
			end
			if (trigLatch) begin
				trigSeen_reg <= 1'b1;
			end
			if (stopCmd || preHit || finish) begin
				if (running) begin
					done_reg <= 1'b1;
				end
				state_reg <= S_IDLE;
			end else begin
				case (state_reg)
					S_IDLE: if (startCmd) begin
						qIdx_reg     <= '0;
						sampCnt_reg  <= '0;
						postCnt_reg  <= '0;
						sweepCnt_reg <= '0;
						trigSeen_reg <= 1'b0;
						done_reg     <= 1'b0;
						if (startMode == MODE_SINGLE) begin
							state_reg <= S_CONVERT;
						end else if (startMode == MODE_SCAN || startTrig == TRIG_POST) begin
							state_reg <= S_WAIT_TRIG;
						end else begin
							state_reg <= S_WAIT_TICK;
						end
					end
					// Only this state accepts a start or retrigger event
					S_WAIT_TRIG: if (trigEvt) begin
						trigSeen_reg <= 1'b1;
						qIdx_reg     <= '0;
						sweepCnt_reg <= '0;
						state_reg    <= isScan ? S_CONVERT : S_WAIT_TICK;
					end
					S_WAIT_TICK: if (paceTick) begin
						state_reg <= S_CONVERT;
					end
					S_CONVERT: if (convDone) begin
						qIdx_reg <= lastEntry ? '0 : qIdx_reg + 10'h001;
						if (!isScan) begin
							state_reg <= S_WAIT_TICK;
						end else if (lastEntry) begin
							sweepCnt_reg <= sweepCnt_reg + 8'h01;
							intCnt_reg   <= '0;
							if (lastSweep) begin
								done_reg <= 1'b1;
							end
							state_reg    <= lastSweep ? S_WAIT_TRIG : S_INTERVAL;
						end
					end
					S_INTERVAL: if (paceTick) begin
						intCnt_reg <= intCnt_reg + 32'h1;
						if (intCnt_reg + 32'h1 >= interval_reg) begin
							state_reg <= S_CONVERT;
						end
					end
					default: state_reg <= S_IDLE;
				endcase
			end
		end
	end

	sample_t    sample_reg;
	logic       sampleValid_reg;
	logic [1:0] aux_reg;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			convBusy_reg    <= 1'b0;
			sampleValid_reg <= 1'b0;
			sample_reg      <= '0;
			aux_reg         <= '0;
		end else begin
			convBusy_reg    <= inConv && !convDone && (convBusy_reg || adcStart);
			sampleValid_reg <= convDone;
			if (convDone) begin
				sample_reg <= curEntry.digital ? sample_t'{digital: 1'b1, data: dioSync} :
					sample_t'{digital: 1'b0, data: {4'h0, adcData}};
				aux_reg <= aux_reg ^ curEntry.sync;
			end
		end
	end
	assign sampleValid = sampleValid_reg;
	assign sample      = sample_reg;
	assign auxOut      = aux_reg;
	assign trigLevel   = trigLevel_reg;
	assign dioOut      = dio_reg[15:0];
	assign dioOe       = {{8{dio_reg[DIO_DIR + 1]}}, {8{dio_reg[DIO_DIR]}}};

	// Waveform output: both channels load from one buffer word on each tick
	logic        aoRun_reg;
	logic        aoArmed_reg;
	logic        dacUpd_reg;
	logic        aoEver_reg;
	logic [11:0] aoIdx_reg;
	logic [31:0] aoCnt_reg;
	logic [11:0] dac0_reg;
	logic [11:0] dac1_reg;
	wire [31:0] aoDivEff = (aoDiv_reg < AO_MIN_DIV) ? AO_MIN_DIV : aoDiv_reg;
	wire aoPacer = aoCnt_reg >= aoDivEff - 32'h1;
	wire aoTick  = aoClkExt ? pinRise[PIN_ACLK] : aoPacer;
	wire [12:0] aoLenEff = 13'((aoLen_reg < AO_MIN_LEN) ? AO_MIN_LEN :
		(aoLen_reg > AO_DEPTH) ? AO_DEPTH : aoLen_reg);
	wire aoLast = {1'b0, aoIdx_reg} == aoLenEff - 13'h0001;
	wire aoTrig = (aoTrigSel == AOT_ACQ) ? (state_reg == S_WAIT_TRIG && trigEvt) :
		(aoTrigSel == AOT_ANALOG) ? pinRise[PIN_CMP] :
		(aoTrigSel == AOT_DIGITAL) ? pinRise[PIN_ATRG] : 1'b1;
	// Same condition as the buffer load below, so the history flag rises with the first new code
	wire aoLoad  = aoRun_reg && aoTick && !aoStopCmd && !aoStartCmd && !(aoArmed_reg && aoTrig);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			aoCnt_reg <= '0;
			aoEver_reg <= 1'b0;
		end else begin
			aoCnt_reg  <= aoPacer ? '0 : aoCnt_reg + 32'h1;
			aoEver_reg <= aoEver_reg || aoLoad;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			aoRun_reg   <= 1'b0;
			aoArmed_reg <= 1'b0;
			aoIdx_reg   <= '0;
			dacUpd_reg  <= 1'b0;
			dac0_reg    <= DAC_ZERO;
			dac1_reg    <= DAC_ZERO;
		end else begin
			dacUpd_reg <= 1'b0;
			if (aoStopCmd) begin
				aoRun_reg   <= 1'b0;
				aoArmed_reg <= 1'b0;
			end else if (aoStartCmd) begin
				aoArmed_reg <= 1'b1;
				aoRun_reg   <= 1'b0;
				aoIdx_reg   <= '0;
			end else if (aoArmed_reg && aoTrig) begin
				aoArmed_reg <= 1'b0;
				aoRun_reg   <= 1'b1;
			end else if (aoRun_reg && aoTick) begin
				{dac1_reg, dac0_reg} <= aoMem[aoIdx_reg];
				dacUpd_reg <= 1'b1;
				aoIdx_reg  <= aoLast ? '0 : aoIdx_reg + 12'h001;
				if (aoLast && !aoCyclic) begin
					aoRun_reg <= 1'b0;
				end
			end
		end
	end
	assign dacUpdate = dacUpd_reg;
	assign dacOut0   = dac0_reg;
	assign dacOut1   = dac1_reg;

	always_comb begin
		case (haddr[7:0])
			OFF_CTRL:     rdMux = ctrl_reg;
			OFF_PACER:    rdMux = pacerDiv_reg;
			OFF_COUNT:    rdMux = sampTarget_reg;
			OFF_SWEEPS:   rdMux = {24'h0, sweepTarget_reg};
			OFF_INTERVAL: rdMux = interval_reg;
			OFF_QLAST:    rdMux = {22'h0, qLast_reg};
			OFF_QADDR:    rdMux = {22'h0, qWrIdx_reg};
			OFF_TLEVEL:   rdMux = {24'h0, trigLevel_reg};
			OFF_POSTCNT:  rdMux = postTarget_reg;
			OFF_STATUS:   rdMux = {sampCnt_reg[15:0], 11'h0, aoArmed_reg, aoRun_reg, trigSeen_reg, done_reg, running};
			OFF_AOLEN:    rdMux = {19'h0, aoLen_reg};
			OFF_AOADDR:   rdMux = {20'h0, aoWrIdx_reg};
			OFF_AODIV:    rdMux = aoDiv_reg;
			OFF_DIO:      rdMux = {14'h0, dio_reg[17:16], dioSync};
			OFF_SAMPLE:   rdMux = {15'h0, sample_reg};
			default:      rdMux = 32'h0;
		endcase
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	a_single_once: assert property (convDone && acqMode == MODE_SINGLE |=> state_reg == S_IDLE && done_reg)
		else $error("single conversion did not end");
	a_stop_idle: assert property (stopCmd |=> state_reg == S_IDLE)
		else $error("stop did not halt");
	a_count_bound: assert property (running && isPaced && sampTarget_reg != 32'h0 |-> sampCnt_reg < sampTarget_reg)
		else $error("sample count overrun");
	a_interval_hold: assert property (state_reg == S_INTERVAL && !paceTick && !stopCmd |=> state_reg == S_INTERVAL)
		else $error("interval ended early");
	a_burst_end: assert property (convDone && isScan && lastEntry && lastSweep && !stopCmd && !finish
		|=> state_reg == S_WAIT_TRIG)
		else $error("burst exceeded sweep count");
	a_tick_wait: assert property (state_reg == S_WAIT_TICK && !paceTick && !stopCmd && !preHit
		|=> state_reg == S_WAIT_TICK)
		else $error("conversion without pace tick");
	a_pre_stop: assert property (preHit && !stopCmd |=> state_reg == S_IDLE && trigSeen_reg)
		else $error("pre-trigger did not stop");
	a_post_start: assert property (state_reg == S_WAIT_TRIG && trigEvt && isPaced && !stopCmd
		|=> state_reg == S_WAIT_TICK && trigSeen_reg)
		else $error("post-trigger did not start");
	a_about_cont: assert property (trigLatch && trigMode == TRIG_ABOUT && !stopCmd && !finish |=> running)
		else $error("about-trigger stopped at trigger");
	a_pacer_gap: assert property (pacerTick |=> !pacerTick [*8])
		else $error("pacer faster than limit");
	a_dac_rate: assert property (dacUpdate |=> !dacUpdate [*8])
		else $error("output update too fast");
	a_dac_zero: assert property (!aoEver_reg |-> dacOut0 == DAC_ZERO && dacOut1 == DAC_ZERO)
		else $error("output not at zero code");
	a_ao_wrap: assert property (aoRun_reg && aoTick && aoLast && aoCyclic && !aoStopCmd && !aoStartCmd
		|=> aoIdx_reg == 12'h000 && aoRun_reg)
		else $error("cyclic output did not wrap");
	a_digital_word: assert property (sampleValid && sample.digital |-> sample.data == $past(dioSync))
		else $error("digital word mismatch");
	a_aux_toggle: assert property (convDone && curEntry.sync[0] |=> auxOut[0] != $past(auxOut[0]))
		else $error("aux output did not toggle");
	a_queue_wrap: assert property (convDone && lastEntry && !stopCmd && !preHit && !finish |=> qIdx_reg == 10'h000)
		else $error("list did not wrap");
	a_retrig_ignore: assert property (inConv && isScan && trigEvt && !convDone && !stopCmd |=> inConv)
		else $error("trigger disturbed burst");

	c_burst_done: cover property (convDone && isScan && lastEntry && lastSweep);
	c_about_done: cover property (finish && aboutHit);
	c_ao_wrap: cover property (aoRun_reg && aoTick && aoLast && aoCyclic);
	c_digital: cover property (sampleValid && sample.digital);
endmodule

// *** hdl/daq_pkg.sv ***
// Constants, types and register map for the acquisition sequencer
// Behaviour
// - Channel list holds 1024 channel/gain entries
// - Each entry picks gain one, two, four, eight
// - One-shot conversion of any chosen channel
// - Paced mode loops list until stop/count
// - Scan mode sweeps fast, waits interval between
// - Each retrigger starts up to 256 sweeps
// - Pacing from internal pacer or external clock
// - Trigger from digital pin or analog threshold
// - Pre-trigger acquires until external trigger arrives
// - Post-trigger starts on trigger, ends at count
// - About-trigger acquires before and after trigger
// - Internal pacer spans 1 S/s to 1.25 MS/s
// - Two 12-bit outputs, synced or independent trigger
// - Outputs update together, up to 500 kS/s from internal pacer
// - Outputs hold zero-volt code after reset
// - Waveform length from two to 4096 samples
// - Cyclic output wraps last sample to first
// - Two 8-bit digital banks, direction per bank
// - Digital-input entry captures all lines as word
// - Aux outputs toggle on designated entry conversion
package daq_pkg;
	localparam int CLK_HZ      = 100_000_000;
	localparam int AI_MAX_SPS  = 1_250_000;
	localparam int AI_MIN_SPS  = 1;
	localparam int AO_MAX_SPS  = 500_000;
	localparam int AI_MIN_DIV  = (CLK_HZ + AI_MAX_SPS - 1) / AI_MAX_SPS;
	localparam int AO_MIN_DIV  = (CLK_HZ + AO_MAX_SPS - 1) / AO_MAX_SPS;
	localparam int QUEUE_DEPTH = 1024;
	localparam int AO_DEPTH    = 4096;
	localparam int AO_MIN_LEN  = 2;

	localparam logic [7:0] OFF_CTRL     = 8'h00;
	localparam logic [7:0] OFF_PACER    = 8'h04;
	localparam logic [7:0] OFF_COUNT    = 8'h08;
	localparam logic [7:0] OFF_SWEEPS   = 8'h0c;
	localparam logic [7:0] OFF_INTERVAL = 8'h10;
	localparam logic [7:0] OFF_QLAST    = 8'h14;
	localparam logic [7:0] OFF_QADDR    = 8'h18;
	localparam logic [7:0] OFF_QDATA    = 8'h1c;
	localparam logic [7:0] OFF_TLEVEL   = 8'h20;
	localparam logic [7:0] OFF_POSTCNT  = 8'h24;
	localparam logic [7:0] OFF_STATUS   = 8'h28;
	localparam logic [7:0] OFF_AOLEN    = 8'h2c;
	localparam logic [7:0] OFF_AOADDR   = 8'h30;
	localparam logic [7:0] OFF_AODATA   = 8'h34;
	localparam logic [7:0] OFF_AODIV    = 8'h38;
	localparam logic [7:0] OFF_DIO      = 8'h3c;
	localparam logic [7:0] OFF_SAMPLE   = 8'h40;

	localparam int CTRL_START   = 0;
	localparam int CTRL_STOP    = 1;
	localparam int CTRL_ACQ     = 2;
	localparam int CTRL_TRIG    = 4;
	localparam int CTRL_SRC     = 6;
	localparam int CTRL_CLKEXT  = 8;
	localparam int CTRL_AOSTART = 9;
	localparam int CTRL_AOSTOP  = 10;
	localparam int CTRL_AOCYC   = 11;
	localparam int CTRL_AOTRIG  = 12;
	localparam int CTRL_AOCLK   = 14;
	localparam int CTRL_SCHAN   = 16;
	localparam int CTRL_SGAIN   = 21;
	localparam int DIO_DIR      = 16;

	localparam logic [1:0] MODE_SINGLE = 2'h0;
	localparam logic [1:0] MODE_PACED  = 2'h1;
	localparam logic [1:0] MODE_SCAN   = 2'h2;
	localparam logic [1:0] TRIG_POST   = 2'h0;
	localparam logic [1:0] TRIG_PRE    = 2'h1;
	localparam logic [1:0] TRIG_ABOUT  = 2'h2;
	localparam logic [1:0] SRC_DIGITAL = 2'h0;
	localparam logic [1:0] SRC_ANALOG  = 2'h1;
	localparam logic [1:0] AOT_ACQ     = 2'h0;
	localparam logic [1:0] AOT_ANALOG  = 2'h1;
	localparam logic [1:0] AOT_DIGITAL = 2'h2;

	localparam int PIN_SCLK = 0;
	localparam int PIN_TRIG = 1;
	localparam int PIN_CMP  = 2;
	localparam int PIN_ACLK = 3;
	localparam int PIN_ATRG = 4;

	localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
	localparam logic [31:0] PACER_RST   = 32'h0000_0050;
	localparam logic [31:0] AODIV_RST   = 32'h0000_00c8;
	localparam logic [12:0] AOLEN_RST   = 13'h0002;
	localparam logic [7:0]  TLEVEL_RST  = 8'h80;
	localparam logic [11:0] DAC_ZERO    = 12'h800;

	typedef enum logic [1:0] {GAIN1, GAIN2, GAIN4, GAIN8} gain_t;
	typedef struct packed {
		logic [1:0] sync;
		logic       digital;
		gain_t      gain;
		logic [4:0] channel;
	} entry_t;
	typedef struct packed {
		logic [4:0] channel;
		gain_t      gain;
	} adcReq_t;
	typedef struct packed {
		logic        digital;
		logic [15:0] data;
	} sample_t;
	typedef enum {S_IDLE, S_WAIT_TRIG, S_WAIT_TICK, S_CONVERT, S_INTERVAL} acqState_t;
endpackage

// *** verification/adc_model.sv ***
// Converter model that answers each request after a settable delay
module adc_model (
	input  wire logic             clock,
	input  wire logic             rst,
	input  wire logic [7:0]       lat,
	input  wire logic             adcStart,
	input  wire daq_pkg::adcReq_t adcReq,
	output logic                  adcDone,
	output logic [11:0]           adcData
);
	timeunit 1ns;
	timeprecision 1ns;
	import daq_pkg::*;
	logic [7:0]  cnt;
	logic [11:0] held;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cnt <= 8'h00;
			adcDone <= 1'b0;
			held <= 12'h000;
		end else begin
			adcDone <= (cnt == 8'h01);
			if (adcStart) begin
				cnt <= (lat == 8'h00) ? 8'h01 : lat;
				held <= {3'h5, adcReq.channel, 2'h0, adcReq.gain};
			end else if (cnt != 8'h00) begin
				cnt <= cnt - 8'h01;
			end
		end
	end
	// Outside the done pulse the data is inverted so stale bits cannot pass
	assign adcData = adcDone ? held : ~held;
endmodule

// *** verification/tb_daq_scan_sequencer.sv ***
// Testbench for the acquisition sequencer
module tb_daq_scan_sequencer;
	timeunit 1ns;
	timeprecision 1ns;
	import daq_pkg::*;
	logic        clock = 0, rst = 1, hsel = 0, hwrite = 0, extSampleClk = 0, extTrig = 0, analogCmp = 0;
	logic        hreadyout, hresp, adcStart, adcDone, sampleValid, dacUpdate;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
	logic [31:0] ent [3] = '{32'h123, 32'h80, 32'h5f};
	logic [31:0] expv [3];
	logic [1:0]  htrans = 0, auxOut;
	logic [7:0]  lat = 8'h03, trigLevel;
	logic [15:0] dioIn = 16'h5aa5, dioOut, dioOe;
	logic [11:0] adcData, dacOut0, dacOut1;
	adcReq_t     adcReq;
	sample_t     sample;
	int          failures = 0, num_checks = 0, cycles = 0, got = 0;
	always #5 clock = ~clock;
	// Free-running external pace, one rising edge every 80 clocks, the fastest conversion rate of the internal pacer
	always begin
		repeat (40) @(posedge clock);
		extSampleClk <= ~extSampleClk;
	end
	daq_scan_sequencer #(.AI_MAX_DIV(1000)) daq_scan_sequencer_inst (.clock, .rst, .hsel, .haddr, .htrans,
		.hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .adcStart, .adcReq,
		.adcDone, .adcData, .sampleValid, .sample, .extSampleClk, .extTrig, .analogCmp, .trigLevel,
		.aoClkIn(1'b0), .aoTrigIn(1'b0), .dacUpdate, .dacOut0, .dacOut1, .dioIn, .dioOut, .dioOe, .auxOut);
	adc_model adc_model_inst (.clock, .rst, .lat, .adcStart, .adcReq, .adcDone, .adcData);
	task automatic finish_test();
		if (failures == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (sampleValid === 1'b1) got <= got + 1;
		if (cycles == 20000) begin
			failures++;
			finish_test();
		end
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			$display("BAD %s exp %h got %h", n, e, g);
			failures++;
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		@(posedge clock);
		while (hreadyout !== 1'b1) @(posedge clock);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clock);
		while (hreadyout !== 1'b1) @(posedge clock);
		rd = hrdata;
	endtask
	task automatic wait_done();
		do bus(0, OFF_STATUS, 0); while (rd[1] !== 1'b1);
	endtask
	function automatic logic [31:0] aval(input logic [4:0] c, input logic [1:0] g);
		return {20'h0, 3'h5, c, 2'h0, g};
	endfunction
	initial begin
		expv = '{aval(5'h03, 2'h1), 32'h0001_5aa5, aval(5'h1f, 2'h2)};
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		chk("dac0", 32'h800, 32'(dacOut0));
		chk("dac1", 32'h800, 32'(dacOut1));
		chk("oe", 32'h0, 32'(dioOe));
		chk("tlevel0", 32'h80, 32'(trigLevel));
		bus(0, 8'h44, 0);
		chk("unmapped", 32'h0, rd);
		bus(1, OFF_CTRL, 32'h0075_0001);
		@(negedge clock iff sampleValid === 1'b1);
		chk("single", aval(5'h15, 2'h3), 32'(sample));
		bus(1, OFF_QADDR, 0);
		foreach (ent[i]) bus(1, OFF_QDATA, ent[i]);
		bus(1, OFF_QLAST, 2);
		bus(1, OFF_COUNT, 7);
		bus(1, OFF_PACER, 80);
		got = 0;
		bus(1, OFF_CTRL, 32'h85);
		for (int i = 0; i < 7; i++) begin
			@(negedge clock iff sampleValid === 1'b1);
			chk("paced", expv[i % 3], 32'(sample));
			if (i == 1 || i == 4) chk("aux", (i == 1) ? 32'h1 : 32'h0, 32'(auxOut));
		end
		wait_done();
		chk("count", 32'd7, got);
		chk("sampcnt", 32'd7, rd >> 16);
		lat <= 8'd20;
		bus(1, OFF_SWEEPS, 1);
		bus(1, OFF_INTERVAL, 2);
		bus(1, OFF_COUNT, 0);
		got = 0;
		bus(1, OFF_CTRL, 32'h109);
		repeat (50) @(posedge clock);
		chk("waits", 32'd0, got);
		extTrig <= 1'b1;
		repeat (5) @(posedge clock);
		extTrig <= 1'b0;
		wait_done();
		chk("sweeps", 32'd6, got);
		bus(1, OFF_CTRL, 32'h2);
		bus(0, OFF_STATUS, 0);
		chk("stopped", 32'h0, rd & 32'h1);
		bus(1, OFF_CTRL, 32'h15);
		repeat (300) @(posedge clock);
		extTrig <= 1'b1;
		repeat (5) @(posedge clock);
		extTrig <= 1'b0;
		wait_done();
		chk("pre", 32'h6, rd & 32'h7);
		chk("prerun", 32'h1, 32'(rd > 32'hffff));
		bus(1, OFF_TLEVEL, 32'h3c);
		bus(1, OFF_POSTCNT, 2);
		chk("tlevel", 32'h3c, 32'(trigLevel));
		bus(1, OFF_CTRL, 32'h65);
		repeat (300) @(posedge clock);
		analogCmp <= 1'b1;
		repeat (5) @(posedge clock);
		analogCmp <= 1'b0;
		wait_done();
		chk("about", 32'h6, rd & 32'h7);
		bus(1, OFF_AOLEN, 2);
		bus(1, OFF_AOADDR, 0);
		bus(1, OFF_AODATA, 32'h123abc);
		bus(1, OFF_AODATA, 32'h456def);
		bus(1, OFF_AODIV, 200);
		bus(1, OFF_CTRL, 32'h1a00);
		repeat (300) @(posedge clock);
		chk("armed", 32'h800, 32'(dacOut0));
		analogCmp <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			@(negedge clock iff dacUpdate === 1'b1);
			chk("dac", (i == 1) ? 32'h456def : 32'h123abc, {8'h0, dacOut1, dacOut0});
		end
		analogCmp <= 1'b0;
		bus(1, OFF_CTRL, 32'h400);
		dioIn <= 16'hc33c;
		bus(1, OFF_DIO, 32'h1_3c5a);
		bus(0, OFF_DIO, 0);
		chk("dioOe", 32'hff, 32'(dioOe));
		chk("dioOut", 32'h3c5a, 32'(dioOut));
		chk("dioIn", 32'hc33c, rd & 32'hffff);
		finish_test();
	end
endmodule
